// ---- src/rfis_defs.svh ----
`ifndef RFIS_DEFS_SVH
`define RFIS_DEFS_SVH
// register indices, then byte addresses (index times four)
`define RFIS_IDX_FLAGS      8'h08
`define RFIS_IDX_BUFSTAT    8'h09
`define RFIS_IDX_COLL       8'h0a
`define RFIS_IDX_TXLO       8'h0b
`define RFIS_IDX_TXHI       8'h0c
`define RFIS_IDX_MASK       8'h0d
`define RFIS_ADDR_FLAGS     12'h020
`define RFIS_ADDR_BUFSTAT   12'h024
`define RFIS_ADDR_COLL      12'h028
`define RFIS_ADDR_TXLO      12'h02c
`define RFIS_ADDR_TXHI      12'h030
`define RFIS_ADDR_MASK      12'h034
// flag bit positions
`define RFIS_BIT_OSC        3'h7
`define RFIS_BIT_FIELD      3'h6
`define RFIS_BIT_LEVEL      3'h5
`define RFIS_BIT_RXEND      3'h4
`define RFIS_BIT_TXEND      3'h3
`define RFIS_BIT_CODING     3'h2
`define RFIS_BIT_CRC        3'h1
`define RFIS_BIT_COLL       3'h0
`define RFIS_RESET_BYTE     8'h00
`define RFIS_BUF_MAX        6'h20
`define RFIS_HTRANS_NONSEQ  2'h2
`endif

// ---- src/rfis_pkg.sv ----
package rfis_pkg;
  typedef struct packed {
    logic       osc_stable;
    logic       field_sensed;
    logic       tx_field_abort;
    logic       level_rx;
    logic       level_tx;
    logic       rx_end;
    logic       tx_end;
    logic       coding_err;
    logic       crc_err;
    logic       bit_coll;
  } rfis_event_type;

  typedef struct packed {
    logic       target_mode;
    logic       enable;
    logic       iso_a_mode;
    logic       rx_start;
    logic [5:0] buf_count;
    logic       buf_overflow;
    logic [3:0] coll_bytes;
    logic [2:0] coll_bits;
  } rfis_status_type;

  typedef struct packed {
    logic        set_default;
    logic        clear;
  } rfis_cmd_type;

  typedef struct packed {
    logic [9:0]  tx_count;
    logic [2:0]  split_bits;
    logic        four_bit_reply_frame;
    logic        anticoll_frame;
  } rfis_txcfg_type;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
  } rfis_aphase_type;

  typedef struct packed {
    rfis_aphase_type ap;
    logic [7:0]      irq_flags;
    logic [7:0]      irq_mask;
    logic [5:0]      buf_count;
    logic            buf_overflow;
    logic            rx_active;
    logic [3:0]      coll_bytes;
    logic [2:0]      coll_bits;
    logic [9:0]      tx_count;
    logic [2:0]      split_bits;
    logic            four_bit_reply_frame;
    logic            anticoll_frame;
    logic [31:0]     rdata;
    logic            irq;
  } rfis_state_type;
endpackage

// ---- src/rfis_regs.sv ----
// Chosen here: register access over AHB-Lite.
`include "rfis_defs.svh"
module rfis_regs
  import rfis_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             hsel_i,
  input  wire logic [11:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  input  wire rfis_event_type   event_i,
  input  wire rfis_status_type  status_i,
  input  wire rfis_cmd_type     cmd_i,
  output rfis_txcfg_type        txcfg_o,
  output logic                  irq_out_pin_o
);
  import rfis_pkg::*;

  rfis_state_type r;
  rfis_state_type next_r;
  logic [7:0]     set_flags;
  logic [7:0]     rd_byte;
  logic           rd_flags;
  logic           wr_en;

  // ----------------------------------------
  // event collection
  // ----------------------------------------
  always_comb
  begin
    set_flags = `RFIS_RESET_BYTE;
    // oscillator settles only while enabled
    set_flags[`RFIS_BIT_OSC] = event_i.osc_stable & status_i.enable;
    set_flags[`RFIS_BIT_FIELD] = (event_i.field_sensed & status_i.target_mode
                                  & ~status_i.enable) | event_i.tx_field_abort;
    set_flags[`RFIS_BIT_LEVEL] = event_i.level_rx | event_i.level_tx;
    set_flags[`RFIS_BIT_RXEND] = event_i.rx_end;
    set_flags[`RFIS_BIT_TXEND] = event_i.tx_end;
    set_flags[`RFIS_BIT_CODING] = event_i.coding_err;
    set_flags[`RFIS_BIT_CRC] = event_i.crc_err;
    set_flags[`RFIS_BIT_COLL] = event_i.bit_coll & status_i.iso_a_mode;
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // read decode works on the live address phase so hrdata stands during the data phase
  assign wr_en    = r.ap.sel & r.ap.write;
  assign rd_flags = hsel_i & hready_i & (htrans_i == `RFIS_HTRANS_NONSEQ) & ~hwrite_i
                    & (haddr_i == `RFIS_ADDR_FLAGS);

  always_comb
  begin
    case (haddr_i)
      `RFIS_ADDR_FLAGS:   rd_byte = r.irq_flags;
      `RFIS_ADDR_BUFSTAT: rd_byte = {r.buf_count, r.buf_overflow, r.rx_active};
      `RFIS_ADDR_COLL:    rd_byte = {r.coll_bytes, r.coll_bits, 1'b0};
      `RFIS_ADDR_TXLO:    rd_byte = {r.tx_count[1:0], r.split_bits, 1'b0,
                                     r.four_bit_reply_frame, r.anticoll_frame};
      `RFIS_ADDR_TXHI:    rd_byte = r.tx_count[9:2];
      `RFIS_ADDR_MASK:    rd_byte = r.irq_mask;
      default:            rd_byte = `RFIS_RESET_BYTE;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.ap.sel   = hsel_i & hready_i & (htrans_i == `RFIS_HTRANS_NONSEQ);
    next_r.ap.write = hwrite_i;
    next_r.ap.addr  = haddr_i;
    // captured at the address edge; holds until the next read is taken
    if (next_r.ap.sel & ~hwrite_i)
    begin
      next_r.rdata = {24'h00_0000, rd_byte};
    end
    // a read wipes the flags, but a same-cycle event survives it
    if (rd_flags)
    begin
      next_r.irq_flags = `RFIS_RESET_BYTE;
    end
    next_r.irq_flags = next_r.irq_flags | set_flags;
    // buffer count follows hardware clipped to RFIS_BUF_MAX; overflow, rx activity and collision position are held
    next_r.buf_count    = (status_i.buf_count > `RFIS_BUF_MAX) ? `RFIS_BUF_MAX
                                                              : status_i.buf_count;
    next_r.buf_overflow = r.buf_overflow | status_i.buf_overflow;
    if (status_i.rx_start)
    begin
      next_r.rx_active = 1'b1;
    end
    else if (event_i.rx_end)
    begin
      next_r.rx_active = 1'b0;
    end
    if (event_i.bit_coll & status_i.iso_a_mode)
    begin
      next_r.coll_bytes = status_i.coll_bytes;
      next_r.coll_bits  = status_i.coll_bits;
    end
    if (wr_en)
    begin
      case (r.ap.addr)
        `RFIS_ADDR_TXLO:
        begin
          next_r.tx_count[1:0]        = hwdata_i[7:6];
          next_r.split_bits           = hwdata_i[5:3];
          next_r.four_bit_reply_frame = hwdata_i[1];
          next_r.anticoll_frame       = hwdata_i[0];
        end
        `RFIS_ADDR_TXHI: next_r.tx_count[9:2] = hwdata_i[7:0];
        `RFIS_ADDR_MASK: next_r.irq_mask = hwdata_i[7:0];
        default: next_r.irq_mask = next_r.irq_mask;
      endcase
    end
    // hardware clear wins over a write landing in the same cycle
    if (event_i.tx_end)
    begin
      next_r.four_bit_reply_frame = 1'b0;
      next_r.anticoll_frame       = 1'b0;
    end
    if (cmd_i.clear | cmd_i.set_default)
    begin
      next_r.buf_count    = 6'h00;
      next_r.buf_overflow = 1'b0;
      next_r.rx_active    = 1'b0;
      next_r.coll_bytes   = 4'h0;
      next_r.coll_bits    = 3'h0;
    end
    if (cmd_i.set_default)
    begin
      next_r.irq_flags            = `RFIS_RESET_BYTE;
      next_r.irq_mask             = `RFIS_RESET_BYTE;
      next_r.tx_count             = 10'h000;
      next_r.split_bits           = 3'h0;
      next_r.four_bit_reply_frame = 1'b0;
      next_r.anticoll_frame       = 1'b0;
    end
    next_r.irq = |(next_r.irq_flags & ~next_r.irq_mask);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata_o    = r.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign irq_out_pin_o = r.irq;
  assign txcfg_o     = '{tx_count: r.tx_count, split_bits: r.split_bits,
                         four_bit_reply_frame: r.four_bit_reply_frame,
                         anticoll_frame: r.anticoll_frame};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_mask_gate;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    1'b1 |-> (irq_out_pin_o == |(r.irq_flags & ~r.irq_mask));
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("irq not mask-gated");

  property p_rx_end;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.rx_end & ~cmd_i.set_default) |=> r.irq_flags[4];
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("rx end flag missing");

  property p_crc;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.crc_err & ~cmd_i.set_default) |=> r.irq_flags[1];
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag missing");

  property p_coll_mode;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ($rose(r.irq_flags[0]) & ~rd_flags) |-> $past(status_i.iso_a_mode);
  endproperty
  a_coll_mode: assert property (p_coll_mode) else $error("collision outside A");

  property p_read_clear;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_flags & ~(|set_flags)) |=> (r.irq_flags == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags not cleared");

  property p_rx_active;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (status_i.rx_start & ~cmd_i.clear & ~cmd_i.set_default) |=> r.rx_active;
  endproperty
  a_rx_active: assert property (p_rx_active) else $error("rx active not set");

  property p_clear_cmd;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd_i.clear |=> (r.coll_bytes == 4'h0 && r.coll_bits == 3'h0 && !r.rx_active);
  endproperty
  a_clear_cmd: assert property (p_clear_cmd) else $error("clear missed");

  property p_frame_clear;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    event_i.tx_end |=> !(txcfg_o.four_bit_reply_frame | txcfg_o.anticoll_frame);
  endproperty
  a_frame_clear: assert property (p_frame_clear) else $error("frame flags kept");

  property p_default;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd_i.set_default |=> (r.irq_mask == 8'h00 && txcfg_o.tx_count == 10'h000);
  endproperty
  a_default: assert property (p_default) else $error("default missed");

  // ----------------------------------------
  // checks: flag sources
  // ----------------------------------------
  property p_osc;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.osc_stable & status_i.enable & ~cmd_i.set_default) |=> r.irq_flags[7];
  endproperty
  a_osc: assert property (p_osc) else $error("osc flag missing");

  property p_osc_gate;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.osc_stable & ~status_i.enable & ~r.irq_flags[7]) |=> !r.irq_flags[7];
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("osc flag while off");

  property p_field_target;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.field_sensed & status_i.target_mode & ~status_i.enable & ~cmd_i.set_default)
      |=> r.irq_flags[6];
  endproperty
  a_field_target: assert property (p_field_target) else $error("field flag missing");

  property p_field_abort;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.tx_field_abort & ~cmd_i.set_default) |=> r.irq_flags[6];
  endproperty
  a_field_abort: assert property (p_field_abort) else $error("abort flag missing");

  property p_level;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ((event_i.level_rx | event_i.level_tx) & ~cmd_i.set_default) |=> r.irq_flags[5];
  endproperty
  a_level: assert property (p_level) else $error("level flag missing");

  property p_tx_end;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.tx_end & ~cmd_i.set_default) |=> r.irq_flags[3];
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx end flag missing");

  property p_coding;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.coding_err & ~cmd_i.set_default) |=> r.irq_flags[2];
  endproperty
  a_coding: assert property (p_coding) else $error("coding flag missing");

  property p_coll_set;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.bit_coll & status_i.iso_a_mode & ~cmd_i.set_default) |=> r.irq_flags[0];
  endproperty
  a_coll_set: assert property (p_coll_set) else $error("collision flag missing");

  property p_coll_gate;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.bit_coll & ~status_i.iso_a_mode & ~r.irq_flags[0]) |=> !r.irq_flags[0];
  endproperty
  a_coll_gate: assert property (p_coll_gate) else $error("collision flag outside A");

  property p_flags_default;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd_i.set_default |=> (r.irq_flags == 8'h00);
  endproperty
  a_flags_default: assert property (p_flags_default) else $error("flags kept");

  property p_flags_stable;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (~rd_flags & ~(|set_flags) & ~cmd_i.set_default) |=> $stable(r.irq_flags);
  endproperty
  a_flags_stable: assert property (p_flags_stable) else $error("flags moved");

  // ----------------------------------------
  // checks: status and configuration
  // ----------------------------------------
  property p_buf_clip;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ((status_i.buf_count > `RFIS_BUF_MAX) & ~cmd_i.clear & ~cmd_i.set_default)
      |=> (r.buf_count == `RFIS_BUF_MAX);
  endproperty
  a_buf_clip: assert property (p_buf_clip) else $error("count not clipped");

  property p_overflow;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (status_i.buf_overflow & ~cmd_i.clear & ~cmd_i.set_default) |=> r.buf_overflow;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow lost");

  property p_rx_stop;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.rx_end & ~status_i.rx_start) |=> !r.rx_active;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx active stuck");

  property p_status_default;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd_i.set_default |=> (r.buf_count == 6'h00 && !r.buf_overflow && !r.rx_active);
  endproperty
  a_status_default: assert property (p_status_default) else $error("status kept");

  property p_coll_capture;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (event_i.bit_coll & status_i.iso_a_mode & ~cmd_i.clear & ~cmd_i.set_default)
      |=> (r.coll_bytes == $past(status_i.coll_bytes) && r.coll_bits == $past(status_i.coll_bits));
  endproperty
  a_coll_capture: assert property (p_coll_capture) else $error("collision not held");

  property p_coll_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (~(event_i.bit_coll & status_i.iso_a_mode) & ~cmd_i.clear & ~cmd_i.set_default)
      |=> ($stable(r.coll_bytes) && $stable(r.coll_bits));
  endproperty
  a_coll_hold: assert property (p_coll_hold) else $error("collision moved");

  property p_coll_default;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd_i.set_default |=> (r.coll_bytes == 4'h0 && r.coll_bits == 3'h0);
  endproperty
  a_coll_default: assert property (p_coll_default) else $error("collision kept");

  property p_mask_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_en & (r.ap.addr == `RFIS_ADDR_MASK) & ~cmd_i.set_default)
      |=> (r.irq_mask == $past(hwdata_i[7:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_txhi_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_en & (r.ap.addr == `RFIS_ADDR_TXHI) & ~cmd_i.set_default)
      |=> (txcfg_o.tx_count[9:2] == $past(hwdata_i[7:0]));
  endproperty
  a_txhi_write: assert property (p_txhi_write) else $error("count not written");

  property p_split_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_en & (r.ap.addr == `RFIS_ADDR_TXLO) & ~cmd_i.set_default)
      |=> (txcfg_o.split_bits == $past(hwdata_i[5:3]));
  endproperty
  a_split_write: assert property (p_split_write) else $error("split not written");

  property p_frame_default;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    cmd_i.set_default |=> (txcfg_o == '0);
  endproperty
  a_frame_default: assert property (p_frame_default) else $error("txcfg kept");
endmodule

// ---- verification/rfis_host_model.sv ----
`include "rfis_defs.svh"
module rfis_host_model
(
  input  wire logic        ref_clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [11:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [31:0]      hwdata_o,
  output logic             hang_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    hsel_o = 1'b0;
    haddr_o = 12'h000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0000_0000;
    hang_o = 1'b0;
  end
  // ------------------------------
  // bus cycles
  // ------------------------------
  // bounded wait: a stuck slave raises hang_o rather than hanging the run
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (hready_i !== 1'b1 && n < 16);
    if (hready_i !== 1'b1)
      hang_o <= 1'b1;
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= `RFIS_HTRANS_NONSEQ;
    hwrite_o <= wr;
    wait_ready();
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~a;
    hwdata_o <= wr ? d : ~hwdata_o;
    wait_ready();
    q = hrdata_i;
    // released data lines must not keep showing the last word
    hwdata_o <= ~hwdata_o;
  endtask
endmodule

// ---- verification/tb_rfis_regs.sv ----
`include "rfis_defs.svh"
module tb_rfis_regs;
  import rfis_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, hsel, hwrite, hready, hresp, irq, hang;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, q;
  rfis_event_type ev = '0;
  rfis_status_type st = '0;
  rfis_cmd_type cmd = '0;
  rfis_txcfg_type tx;
  int err_count = 0, n_checks = 0;
  always #10 clk = ~clk;
  rfis_host_model host (.ref_clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata), .hang_o(hang));
  rfis_regs DUT (.ref_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .event_i(ev), .status_i(st),
    .cmd_i(cmd), .txcfg_o(tx), .irq_out_pin_o(irq));
  // ------------------------------
  // helpers
  // ------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task rdc(input logic [11:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), {24'h0, e}, q);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, q);
    #1;
  endtask
  task pulse(input rfis_event_type e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask
  task end_sim();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge hang)
  begin
    err_count++;
    end_sim();
  end
  // ------------------------------
  // scenarios
  // ------------------------------
  task t_reset();
    logic [11:0] a[7] = '{12'h020, 12'h024, 12'h028, 12'h02c, 12'h030, 12'h034, 12'h038};
    foreach (a[i])
      rdc(a[i], 8'h00);
    chk("hready", 1, hready);
    chk("hresp", 0, hresp);
    wr(`RFIS_ADDR_FLAGS, 8'hff);
    rdc(`RFIS_ADDR_FLAGS, 8'h00);
  endtask
  task t_flags();
    logic [7:0] e[10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h20, 8'h40, 8'h40, 8'h80};
    st.target_mode <= 1'b1;
    st.iso_a_mode <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      st.enable <= (i == 9);
      pulse(rfis_event_type'(10'h1 << i));
      chk("irq", 1, irq);
      rdc(`RFIS_ADDR_FLAGS, e[i]);
      rdc(`RFIS_ADDR_FLAGS, 8'h00);
      chk("irq", 0, irq);
    end
    st.iso_a_mode <= 1'b0;
    pulse(rfis_event_type'(10'h1));
    rdc(`RFIS_ADDR_FLAGS, 8'h00);
  endtask
  task t_mask();
    wr(`RFIS_ADDR_MASK, 8'h10);
    pulse(rfis_event_type'(10'h10));
    chk("irq", 0, irq);
    pulse(rfis_event_type'(10'h08));
    chk("irq", 1, irq);
    wr(`RFIS_ADDR_MASK, 8'h18);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    rdc(`RFIS_ADDR_MASK, 8'h18);
    rdc(`RFIS_ADDR_FLAGS, 8'h18);
    wr(`RFIS_ADDR_MASK, 8'h00);
  endtask
  task t_status();
    st <= '{iso_a_mode: 1, buf_count: 6'h3f, coll_bytes: 4'h9, coll_bits: 3'h5, default: 0};
    @(posedge clk);
    st.rx_start <= 1'b1;
    st.buf_overflow <= 1'b1;
    @(posedge clk);
    st.rx_start <= 1'b0;
    st.buf_overflow <= 1'b0;
    pulse(rfis_event_type'(10'h01));
    rdc(`RFIS_ADDR_BUFSTAT, 8'h83);
    rdc(`RFIS_ADDR_COLL, 8'h9a);
    pulse(rfis_event_type'(10'h10));
    rdc(`RFIS_ADDR_BUFSTAT, 8'h82);
    st.buf_count <= 6'h00;
    @(posedge clk);
    cmd.clear <= 1'b1;
    @(posedge clk);
    cmd.clear <= 1'b0;
    rdc(`RFIS_ADDR_BUFSTAT, 8'h00);
    rdc(`RFIS_ADDR_COLL, 8'h00);
    rdc(`RFIS_ADDR_FLAGS, 8'h11);
  endtask
  task t_txcfg();
    wr(`RFIS_ADDR_TXLO, 8'heb);
    wr(`RFIS_ADDR_TXHI, 8'hff);
    chk("tx", {10'h3ff, 3'h5, 2'h3}, tx);
    pulse(rfis_event_type'(10'h08));
    @(posedge clk);
    #1;
    chk("tx", {10'h3ff, 3'h5, 2'h0}, tx);
    rdc(`RFIS_ADDR_TXLO, 8'he8);
    rdc(`RFIS_ADDR_FLAGS, 8'h08);
    wr(`RFIS_ADDR_MASK, 8'h55);
    @(posedge clk);
    cmd.set_default <= 1'b1;
    @(posedge clk);
    cmd.set_default <= 1'b0;
    rdc(`RFIS_ADDR_TXLO, 8'h00);
    rdc(`RFIS_ADDR_TXHI, 8'h00);
    rdc(`RFIS_ADDR_MASK, 8'h00);
    chk("tx", 0, tx);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_mask();
    t_status();
    t_txcfg();
    end_sim();
  end
endmodule
